/* File: kbi_checker.sv */
// Concurrent checks on the keyboard pin interrupt ports.
// Assumes the event mask stays zero, so only the gate drives irq_o.
`timescale 1ns/1ps
module kbi_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire kbi_pkg::apb_req_type apb_req_i,
  input wire kbi_pkg::apb_rsp_type apb_rsp_o,
  input wire logic [kbi_pkg::PIN_COUNT-1:0] pins_i,
  input wire logic stop_i,
  input wire logic irq_o,
  input wire logic wake_o
);
  logic [7:0] sc_reg, en_reg, d1_reg, d2_reg, d3_reg;
  logic wr, ack_wr;
  assign wr = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready
    && apb_req_i.pwrite;
  assign ack_wr = wr && apb_req_i.paddr[7:2] == 6'h00 && apb_req_i.pwdata[2];
  // ----
  // Shadow of written control state
  // ----
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_reg <= 8'h00;
      en_reg <= 8'h00;
    end else if (wr && apb_req_i.paddr[7:2] == 6'h00) begin
      sc_reg <= apb_req_i.pwdata[7:0];
    end else if (wr && apb_req_i.paddr[7:2] == 6'h01) begin
      en_reg <= apb_req_i.pwdata[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    d1_reg <= pins_i;
    d2_reg <= d1_reg;
    d3_reg <= d2_reg;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_ready_after_setup: assert property (
    apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready)
    else $error("pready missing after setup");
  a_ack_reads_zero: assert property (
    apb_rsp_o.pready && !apb_req_i.pwrite && apb_req_i.paddr[7:2] == 6'h00
    |-> !apb_rsp_o.prdata[2]) else $error("ack bit read as one");
  a_wake_needs_stop: assert property (
    !stop_i |-> !wake_o) else $error("wake outside stop");
  a_wake_needs_enable: assert property (
    en_reg == 8'h00 |-> !wake_o) else $error("wake with no pin enabled");
  a_irq_gated_off: assert property (
    !sc_reg[1] && !$past(sc_reg[1]) |-> !irq_o) else $error("irq ungated");
  a_lower_fall_irq: assert property (
    sc_reg[1] && en_reg[0] && d1_reg[0] && !pins_i[0] |-> ##3 irq_o)
    else $error("falling edge on pin 0 missed");
  a_upper_rise_irq: assert property (
    sc_reg[1] && sc_reg[4] && en_reg[4] && !d1_reg[4] && pins_i[4]
    |-> ##3 irq_o) else $error("rising edge on pin 4 missed");
  a_level_holds_irq: assert property (
    sc_reg[1] && sc_reg[0] && en_reg[0] && !pins_i[0] && !d1_reg[0]
    && !d2_reg[0] |=> irq_o) else $error("held level lost the flag");
  // The edge seen at the ack edge comes from pins two and three back
  a_ack_clears_irq: assert property (
    ack_wr && !sc_reg[0] && !stop_i && d2_reg == d3_reg |=> !irq_o)
    else $error("acknowledge left irq high");
  c_level_ack: cover property (ack_wr && irq_o);
  c_wake: cover property (wake_o);
  c_unmapped: cover property (apb_rsp_o.pslverr);
endmodule
bind keyboard_pin_interrupt kbi_checker u_checker (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .pins_i(pins_i), .stop_i(stop_i),
  .irq_o(irq_o), .wake_o(wake_o));

/* File: kbi_pkg.sv */
// Constants and carrier types for the keyboard pin interrupt block.
// Assumes a 32-bit APB master and eight port pins sampled on clk_i.
package kbi_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int PIN_COUNT = 8;
  localparam int UPPER_COUNT = 4;
  localparam int EVENT_COUNT = 3;
  localparam int ADDR_WIDTH = 8;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PIN_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h0C;

  // ------------------------------------------------------------
  // Status/control field positions
  // ------------------------------------------------------------
  localparam int SC_POLARITY_LSB = 4;
  localparam int SC_PENDING_BIT = 3;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_GATE_BIT = 1;
  localparam int SC_MODE_BIT = 0;

  // Event status / mask bit positions
  localparam int EVT_EDGE_BIT = 0;
  localparam int EVT_ACK_BLOCKED_BIT = 1;
  localparam int EVT_WAKE_BIT = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0] POLARITY_RESET = 4'h0;
  localparam logic GATE_RESET = 1'b0;
  localparam logic MODE_RESET = 1'b0;
  localparam logic PENDING_RESET = 1'b0;
  localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic [2:0] EVENT_STATUS_RESET = 3'h0;
  localparam logic [2:0] EVENT_MASK_RESET = 3'h0;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage

/* File: key_pad_model.sv */
// Key bank in front of the eight keyboard pins.
// Assumes the bench changes keys right after a rising clock edge.
`timescale 1ns/1ps
module key_pad_model (
  input wire logic [7:0] press_i,
  input wire logic [7:0] pull_down_i,
  output logic [7:0] pins_o
);
  // A pressed key drives its pin against the pin's pull device
  assign pins_o = press_i ^ ~pull_down_i;
endmodule

/* File: keyboard_pin_interrupt.sv */
// Eight-input keyboard interrupt detector with an APB register slave.
// Assumes pins_i is synchronous to clk_i in simulation, still synchronised.
`timescale 1ns/1ps

module keyboard_pin_interrupt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire kbi_pkg::apb_req_type apb_req_i,
  output kbi_pkg::apb_rsp_type apb_rsp_o,
  input wire logic [kbi_pkg::PIN_COUNT-1:0] pins_i,
  input wire logic stop_i,
  output logic irq_o,
  output logic wake_o
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [kbi_pkg::UPPER_COUNT-1:0] upper_input_polarity_reg;
  logic pending_flag_reg;
  logic irq_gate_reg;
  logic detect_mode_select_reg;
  logic [kbi_pkg::PIN_COUNT-1:0] keypad_pin_enable_reg;
  logic [kbi_pkg::EVENT_COUNT-1:0] event_status_reg;
  logic [kbi_pkg::EVENT_COUNT-1:0] event_mask_reg;
  logic irq_reg;

  // ------------------------------------------------------------
  // Pin sampling state
  // ------------------------------------------------------------
  logic [kbi_pkg::PIN_COUNT-1:0] sync_first_reg;
  logic [kbi_pkg::PIN_COUNT-1:0] sync_second_reg;
  logic [kbi_pkg::PIN_COUNT-1:0] seen_deasserted_reg;

  // ------------------------------------------------------------
  // Bus answer state
  // ------------------------------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  logic [kbi_pkg::PIN_COUNT-1:0] polarity_full;
  logic [kbi_pkg::PIN_COUNT-1:0] asserted;
  logic [kbi_pkg::PIN_COUNT-1:0] enabled_asserted;
  logic [kbi_pkg::PIN_COUNT-1:0] edge_vec;
  logic [kbi_pkg::PIN_COUNT-1:0] raw_asserted;
  logic edge_event;
  logic level_hold;
  logic set_pending;
  logic ack_write;
  logic ack_blocked;
  logic stop_level;
  logic [kbi_pkg::EVENT_COUNT-1:0] event_set;
  logic pending_next;
  logic [kbi_pkg::EVENT_COUNT-1:0] event_status_next;

  logic setup_phase;
  logic access_done;
  logic bus_write;
  logic [7:0] word_addr;
  logic sel_sc;
  logic sel_pe;
  logic sel_es;
  logic sel_em;
  logic [31:0] read_value;

  // ------------------------------------------------------------
  // Trigger sense
  // ------------------------------------------------------------
  // Lower inputs are hard-wired to falling/low sense.
  assign polarity_full = {upper_input_polarity_reg, 4'h0};
  // Sense per pin: polarity 1 asserts on high, 0 on low.
  assign asserted = ~(sync_second_reg ^ polarity_full);
  assign enabled_asserted = asserted & keypad_pin_enable_reg;

  // Edge: previous sample deasserted, present sample asserted. Since
  // seen_deasserted_reg only holds for enabled pins, a pin just enabled
  // at its asserted level produces no edge.
  assign edge_vec = enabled_asserted & seen_deasserted_reg;

  always_comb begin
    edge_event = 1'b0;
    if (detect_mode_select_reg) begin
      // Every enabled asserted pin must be a fresh edge.
      edge_event = (|edge_vec) && (edge_vec == enabled_asserted);
    end else begin
      edge_event = |edge_vec;
    end
  end

  assign level_hold = detect_mode_select_reg & (|enabled_asserted);

  // Level seen on the way out of stop stands in for the missed edge.
  assign stop_level = stop_i & (|enabled_asserted);
  assign set_pending = edge_event | level_hold | stop_level;

  // ------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------
  assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
  assign access_done = apb_req_i.psel & apb_req_i.penable & pready_reg;
  assign bus_write = access_done & apb_req_i.pwrite;
  assign word_addr = {apb_req_i.paddr[7:2], 2'b00};

  always_comb begin
    sel_sc = 1'b0;
    sel_pe = 1'b0;
    sel_es = 1'b0;
    sel_em = 1'b0;
    if (word_addr == kbi_pkg::ADDR_STATUS_CONTROL) begin
      sel_sc = 1'b1;
    end else if (word_addr == kbi_pkg::ADDR_PIN_ENABLE) begin
      sel_pe = 1'b1;
    end else if (word_addr == kbi_pkg::ADDR_EVENT_STATUS) begin
      sel_es = 1'b1;
    end else if (word_addr == kbi_pkg::ADDR_EVENT_MASK) begin
      sel_em = 1'b1;
    end
  end

  assign ack_write = bus_write & sel_sc
    & apb_req_i.pwdata[kbi_pkg::SC_ACK_BIT];
  assign ack_blocked = ack_write & set_pending;

  // Set wins over acknowledge in the same cycle.
  always_comb begin
    pending_next = pending_flag_reg;
    if (set_pending) begin
      pending_next = 1'b1;
    end else if (ack_write) begin
      pending_next = 1'b0;
    end
  end

  always_comb begin
    event_set = '0;
    event_set[kbi_pkg::EVT_EDGE_BIT] = edge_event;
    event_set[kbi_pkg::EVT_ACK_BLOCKED_BIT] = ack_blocked;
    event_set[kbi_pkg::EVT_WAKE_BIT] = stop_level;
  end

  // Write-one-to-clear, with a simultaneous set winning.
  always_comb begin
    event_status_next = event_status_reg;
    if (bus_write && sel_es) begin
      event_status_next = event_status_reg
        & ~apb_req_i.pwdata[kbi_pkg::EVENT_COUNT-1:0];
    end
    event_status_next = event_status_next | event_set;
  end

  always_comb begin
    read_value = 32'h0000_0000;
    if (sel_sc) begin
      read_value[7:4] = upper_input_polarity_reg;
      read_value[kbi_pkg::SC_PENDING_BIT] = pending_flag_reg;
      read_value[kbi_pkg::SC_GATE_BIT] = irq_gate_reg;
      read_value[kbi_pkg::SC_MODE_BIT] = detect_mode_select_reg;
    end else if (sel_pe) begin
      read_value[7:0] = keypad_pin_enable_reg;
    end else if (sel_es) begin
      read_value[2:0] = event_status_reg;
    end else if (sel_em) begin
      read_value[2:0] = event_mask_reg;
    end
  end

  // ------------------------------------------------------------
  // Pin synchroniser and deasserted history
  // ------------------------------------------------------------
  // Asynchronous key bounces would otherwise reach the flag directly.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_first_reg <= 8'h00;
      sync_second_reg <= 8'h00;
    end else if (ce_i) begin
      sync_first_reg <= pins_i;
      sync_second_reg <= sync_first_reg;
    end
  end

  // Cleared in stop: the edge path is bypassed while clocks are held.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_deasserted_reg <= 8'h00;
    end else if (ce_i && !stop_i) begin
      seen_deasserted_reg <= ~asserted & keypad_pin_enable_reg;
    end else if (ce_i) begin
      seen_deasserted_reg <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_input_polarity_reg <= kbi_pkg::POLARITY_RESET;
      irq_gate_reg <= kbi_pkg::GATE_RESET;
      detect_mode_select_reg <= kbi_pkg::MODE_RESET;
    end else if (ce_i && bus_write && sel_sc) begin
      upper_input_polarity_reg <= apb_req_i.pwdata[7:4];
      irq_gate_reg <= apb_req_i.pwdata[kbi_pkg::SC_GATE_BIT];
      detect_mode_select_reg <=
        apb_req_i.pwdata[kbi_pkg::SC_MODE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_pin_enable_reg <= kbi_pkg::PIN_ENABLE_RESET;
    end else if (ce_i && bus_write && sel_pe) begin
      keypad_pin_enable_reg <= apb_req_i.pwdata[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_mask_reg <= kbi_pkg::EVENT_MASK_RESET;
    end else if (ce_i && bus_write && sel_em) begin
      event_mask_reg <= apb_req_i.pwdata[kbi_pkg::EVENT_COUNT-1:0];
    end
  end

  // ------------------------------------------------------------
  // Flags and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_flag_reg <= kbi_pkg::PENDING_RESET;
      event_status_reg <= kbi_pkg::EVENT_STATUS_RESET;
    end else if (ce_i) begin
      pending_flag_reg <= pending_next;
      event_status_reg <= event_status_next;
    end
  end

  // Built from next values so the request moves with the flags.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= (irq_gate_reg & pending_next)
        | (|(event_status_next & event_mask_reg));
    end
  end

  // ------------------------------------------------------------
  // APB answer: one wait-free access phase per transfer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_reg <= setup_phase;
      if (setup_phase) begin
        pslverr_reg <= ~(sel_sc | sel_pe | sel_es | sel_em);
        prdata_reg <= apb_req_i.pwrite ? 32'h0000_0000 : read_value;
      end else begin
        pslverr_reg <= 1'b0;
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign apb_rsp_o.pready = pready_reg;
  assign apb_rsp_o.pslverr = pslverr_reg;
  assign apb_rsp_o.prdata = prdata_reg;
  assign irq_o = irq_reg;

  // Wake path must work with clk_i stopped, so it is left unregistered.
  assign raw_asserted = ~(pins_i ^ polarity_full);
  assign wake_o = stop_i & (|(raw_asserted & keypad_pin_enable_reg));

endmodule

/* File: keyboard_pin_interrupt_tb_top.sv */
// Self-checking bench for the keyboard pin interrupt block.
// Assumes the key model on the pins; ce_i drops once to test freezing.
`timescale 1ns/1ps
module keyboard_pin_interrupt_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stop_i = 1'b0;
  logic ce_i = 1'b1;
  logic irq_o, wake_o;
  logic [7:0] press = 8'h00;
  logic [7:0] pull_down = 8'h00;
  logic [7:0] pins;
  logic [31:0] seed = 32'h00006AE1;
  int n_mismatch = 0;
  int n_tests = 0;
  kbi_pkg::apb_req_type req = '0;
  kbi_pkg::apb_rsp_type rsp;
  keyboard_pin_interrupt u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .apb_req_i(req), .apb_rsp_o(rsp), .pins_i(pins), .stop_i(stop_i),
    .irq_o(irq_o), .wake_o(wake_o));
  key_pad_model u_keys (.press_i(press), .pull_down_i(pull_down),
    .pins_o(pins));
  initial forever #10 clk_i = ~clk_i;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] sc_exp(input logic [3:0] pol,
      input logic pend, input logic gate, input logic mode);
    return {24'h000000, pol, pend, 1'b0, gate, mode};
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail(input string msg);
    n_mismatch++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask
  task automatic check_line(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) fail($sformatf("line %b expected %b", got, exp));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [32:0] q);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (n >= 16) fail("no pready");
    if (n >= 16) complete_run();
    q = {rsp.pslverr, rsp.prdata};
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [32:0] q;
    apb(1'b0, a, 32'h00000000, q);
    check_reg(q[31:0], exp);
    check_line(q[32], a > 8'h0C);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    logic [31:0] r;
    logic [3:0] pol;
    idle(12);
    rst_i <= 1'b0;
    rd(8'h00, 32'h00000000);
    rd(8'h04, 32'h00000000);
    rd(8'h10, 32'h00000000);
    $display("Test reset done");
    // Edge-only mode, so enabling an asserted pin stays quiet
    for (int i = 0; i < 8; i++) begin
      r = xs();
      wr(8'h04, 32'h00000000);
      wr(8'h00, r & 32'hFFFFFFFE);
      rd(8'h00, r & 32'h000000F2);
      wr(8'h04, r >> 8);
      rd(8'h04, (r >> 8) & 32'h000000FF);
    end
    $display("Test random registers done");
    // Upper pins take both senses: 4 and 6 rising, 5 and 7 falling
    for (int i = 0; i < 8; i++) begin
      pol = (i[2] ^ i[0]) ? 4'hF : 4'h0;
      wr(8'h04, 32'h00000000);
      pull_down <= {pol, 4'h0};
      wr(8'h00, {24'h000000, pol, 4'h6});
      wr(8'h04, 32'h00000001 << i);
      press <= 8'h01 << (i ^ 1);
      idle(6);
      check_line(irq_o, 1'b0);
      press <= 8'h01 << i;
      idle(6);
      check_line(irq_o, 1'b1);
      rd(8'h00, sc_exp(pol, 1'b1, 1'b1, 1'b0));
      press <= 8'h00;
      idle(6);
      wr(8'h00, {24'h000000, pol, 4'h6});
      check_line(irq_o, 1'b0);
      rd(8'h00, sc_exp(pol, 1'b0, 1'b1, 1'b0));
    end
    $display("Test edges done");
    wr(8'h04, 32'h00000000);
    pull_down <= 8'h00;
    wr(8'h08, 32'h00000007);
    wr(8'h00, 32'h00000007);
    wr(8'h04, 32'h00000003);
    press <= 8'h01;
    idle(6);
    wr(8'h00, 32'h00000007);
    rd(8'h00, sc_exp(4'h0, 1'b1, 1'b1, 1'b1));
    rd(8'h08, 32'h00000003);
    press <= 8'h00;
    idle(6);
    wr(8'h00, 32'h00000007);
    rd(8'h00, sc_exp(4'h0, 1'b0, 1'b1, 1'b1));
    wr(8'h08, 32'h00000003);
    rd(8'h08, 32'h00000000);
    $display("Test level mode done");
    wr(8'h00, 32'h00000004);
    stop_i <= 1'b1;
    idle(2);
    check_line(wake_o, 1'b0);
    press <= 8'h02;
    idle(1);
    check_line(wake_o, 1'b1);
    // Held until the synchroniser has it while still stopped
    idle(2);
    press <= 8'h00;
    stop_i <= 1'b0;
    idle(1);
    check_line(wake_o, 1'b0);
    rd(8'h00, sc_exp(4'h0, 1'b1, 1'b0, 1'b0));
    rd(8'h08, 32'h00000004);
    check_line(irq_o, 1'b0);
    wr(8'h00, 32'h00000002);
    // Request follows the gate one edge after the write lands
    idle(1);
    check_line(irq_o, 1'b1);
    $display("Test stop and gate done");
    wr(8'h00, 32'h00000006);
    check_line(irq_o, 1'b0);
    // Frozen state must not notice a key pressed while ce_i is low
    ce_i <= 1'b0;
    press <= 8'h01;
    idle(6);
    check_line(irq_o, 1'b0);
    ce_i <= 1'b1;
    idle(6);
    check_line(irq_o, 1'b1);
    $display("Test clock enable done");
    complete_run();
  end
endmodule
